// ==== jtag_pin_map.vh ====
// Purpose: Constants for the scan-pin sharing block
// Assumes: 10 MHz system clock
// Notes:   Included by the pin mux and its TAP tracker
`ifndef JTAG_PIN_MAP_VH
`define JTAG_PIN_MAP_VH

// TAP state codes (4 bits)
`define TAP_RESET       4'h0
`define TAP_IDLE        4'h1
`define TAP_SEL_DR      4'h2
`define TAP_CAP_DR      4'h3
`define TAP_SHIFT_DR    4'h4
`define TAP_EXIT1_DR    4'h5
`define TAP_PAUSE_DR    4'h6
`define TAP_EXIT2_DR    4'h7
`define TAP_UPD_DR      4'h8
`define TAP_SEL_IR      4'h9
`define TAP_CAP_IR      4'hA
`define TAP_SHIFT_IR    4'hB
`define TAP_EXIT1_IR    4'hC
`define TAP_PAUSE_IR    4'hD
`define TAP_EXIT2_IR    4'hE
`define TAP_UPD_IR      4'hF

// Reset value of the pin-mode control
`define MODE_RST_DEDICATED 1'h0

// Reset value of the test-reset reservation register (not reserved)
`define TRST_RSV_RST       1'h0

// Reset level of each pin synchroniser stage; mode-select high keeps the TAP in reset
`define PIN_SYNC_RST       1'h1

// Reset value of the last link clock sample; equals the synchroniser level so
// that reset release never shows a false rising edge
`define TCK_LAST_RST       1'h1

`endif

// ==== tap_tracker.v ====
// Purpose: Scan TAP state machine, advanced on sampled link clock edges
// Assumes: Inputs already synchronised to i_sys_clk
// Notes:   Test reset clears the state asynchronously through the caller's reset
`timescale 1ns/1ps
`include "jtag_pin_map.vh"

module tap_tracker (
    // Clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rst_n,
    // Sampled link
    input  wire       i_tck_rise,
    input  wire       i_tms,
    // State
    output reg  [3:0] o_state_reg
);

    reg [3:0] state_next;

    // Standard sixteen-state walk; five TMS-high edges reach reset from any state
    always @* begin
        state_next = o_state_reg;
        case (o_state_reg)
            `TAP_RESET:    state_next = i_tms ? `TAP_RESET    : `TAP_IDLE;
            `TAP_IDLE:     state_next = i_tms ? `TAP_SEL_DR   : `TAP_IDLE;
            `TAP_SEL_DR:   state_next = i_tms ? `TAP_SEL_IR   : `TAP_CAP_DR;
            `TAP_CAP_DR:   state_next = i_tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
            `TAP_SHIFT_DR: state_next = i_tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
            `TAP_EXIT1_DR: state_next = i_tms ? `TAP_UPD_DR   : `TAP_PAUSE_DR;
            `TAP_PAUSE_DR: state_next = i_tms ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
            `TAP_EXIT2_DR: state_next = i_tms ? `TAP_UPD_DR   : `TAP_SHIFT_DR;
            `TAP_UPD_DR:   state_next = i_tms ? `TAP_SEL_DR   : `TAP_IDLE;
            `TAP_SEL_IR:   state_next = i_tms ? `TAP_RESET    : `TAP_CAP_IR;
            `TAP_CAP_IR:   state_next = i_tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
            `TAP_SHIFT_IR: state_next = i_tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
            `TAP_EXIT1_IR: state_next = i_tms ? `TAP_UPD_IR   : `TAP_PAUSE_IR;
            `TAP_PAUSE_IR: state_next = i_tms ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
            `TAP_EXIT2_IR: state_next = i_tms ? `TAP_UPD_IR   : `TAP_SHIFT_IR;
            `TAP_UPD_IR:   state_next = i_tms ? `TAP_SEL_DR   : `TAP_IDLE;
            default:       state_next = `TAP_RESET;
        endcase
    end

    // Power-up lands in Test-Logic-Reset
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_state_reg <= `TAP_RESET;
        end else if (i_tck_rise) begin
            o_state_reg <= state_next;
        end
    end

endmodule // tap_tracker

// ==== jtag_pin_mode_control.v ====
// Purpose: Shares the boundary-scan pins between the test port and user I/O
// Assumes: Link clock far slower than i_sys_clk; all pin inputs asynchronous
// Notes:   Pull-up enables are outputs for the pad ring; no pad is modelled here
//          The two reservation straps are sampled every clock, so a change there lands one clock late
//          The reserved test-reset pin reaches the TAP reset without a synchroniser
//
// Functional notes
// - Mode-select pin is never routed to user logic, in either mode.
// - Dedicated mode keeps every scan pin except an unreserved test-reset pin for test use only.
// - Dedicated mode enables pull-ups on mode-select and data-in pins.
// - Dedicated mode: mode-select drives the standard TAP state walk.
// - Reservation option cleared means flexible mode, the default.
// - Flexible mode: data-in, clock, data-out roles chosen by the TAP state.
// - Flexible mode leaves mode-select and data-in pull-ups off.
// - TAP starts in Test-Logic-Reset at power-up.
// - Flexible mode in Test-Logic-Reset: three shared pins act as user I/O; here data-out is output only, o_user_tdo_in held at 0.
// - Rising link clock with mode-select low hands pins to the test port.
// - Reserved test-reset pin asynchronously resets the scan logic.
// - Reserved test-reset pin keeps its pull-up on always.
// - Unreserved test-reset pin is user I/O; unused means tristated output.
`timescale 1ns/1ps
`include "jtag_pin_map.vh"

module jtag_pin_mode_control (
    // Clock and reset
    input  wire i_sys_clk,
    input  wire i_rst_n,
    // Configuration (static straps)
    input  wire i_reserve_jtag,
    input  wire i_reserve_trst,
    input  wire i_trst_user_used,
    // Scan pins from the pads
    input  wire i_tms_pin,
    input  wire i_tck_pin,
    input  wire i_tdi_pin,
    input  wire i_trst_pin,
    // Test data out driven toward the pad
    input  wire i_tdo_test,
    // User logic driving the shared pins
    input  wire i_user_tck_out,
    input  wire i_user_tck_oe,
    input  wire i_user_tdi_out,
    input  wire i_user_tdi_oe,
    input  wire i_user_tdo_out,
    input  wire i_user_tdo_oe,
    input  wire i_user_trst_out,
    input  wire i_user_trst_oe,
    // Pad drive
    output reg  o_tck_out,
    output reg  o_tck_oe,
    output reg  o_tdi_out,
    output reg  o_tdi_oe,
    output reg  o_tdo_out,
    output reg  o_tdo_oe,
    output reg  o_trst_out,
    output reg  o_trst_oe,
    // Pull-up enables
    output reg  o_tms_pullup_en,
    output reg  o_tdi_pullup_en,
    output reg  o_trst_pullup_en,
    // Values seen by user logic
    output reg  o_user_tck_in,
    output reg  o_user_tdi_in,
    output reg  o_user_tdo_in,
    output reg  o_user_trst_in,
    // Test-port view
    output reg  o_test_owns_pins,
    output reg  o_tck_rise,
    output reg  o_tms_sync,
    output reg  o_tdi_sync,
    output reg  o_tap_reset,
    output reg  [3:0] o_tap_state
);

    // Pin positions inside the synchroniser vectors
    localparam integer PIN_TMS  = 0;
    localparam integer PIN_TCK  = 1;
    localparam integer PIN_TDI  = 2;
    localparam integer PIN_TRST = 3;
    localparam integer NUM_PINS = 4;

    // Raw pad inputs and their synchronised copies
    wire [NUM_PINS-1:0] pin_raw;
    wire [NUM_PINS-1:0] pin_sync;
    // Link clock edge detector and strap registers
    reg                 tck_last_reg;
    reg                 mode_flex_reg;
    reg                 trst_rsv_reg;
    // Named views of the synchronised pins
    wire                tms_s;
    wire                tck_s;
    wire                tdi_s;
    wire                trst_s;
    // TAP reset and link clock edge inputs, TAP state and its reset-state decode
    wire [3:0]          state;
    wire                tap_rst_n;
    wire                tck_rise;
    wire                in_reset;
    genvar              gi;

    // Gather the asynchronous pad inputs in one vector
    assign pin_raw[PIN_TMS]  = i_tms_pin;
    assign pin_raw[PIN_TCK]  = i_tck_pin;
    assign pin_raw[PIN_TDI]  = i_tdi_pin;
    assign pin_raw[PIN_TRST] = i_trst_pin;

    // One two-flop synchroniser per pin; only the second stage is read, so a
    // metastable first stage never reaches the TAP or the pad steering
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_sync
            reg stage1_reg;
            reg stage2_reg;
            always @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    stage1_reg <= `PIN_SYNC_RST;
                    stage2_reg <= `PIN_SYNC_RST;
                end else begin
                    stage1_reg <= pin_raw[gi];
                    stage2_reg <= stage1_reg;
                end
            end
            assign pin_sync[gi] = stage2_reg;
        end
    endgenerate

    // Named views used by the rest of the block
    assign tms_s  = pin_sync[PIN_TMS];
    assign tck_s  = pin_sync[PIN_TCK];
    assign tdi_s  = pin_sync[PIN_TDI];
    assign trst_s = pin_sync[PIN_TRST];

    // Last sampled link clock; its reset level matches the synchroniser's so
    // the release of reset is never mistaken for a rising link clock edge
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tck_last_reg <= `TCK_LAST_RST;
        end else begin
            tck_last_reg <= tck_s;
        end
    end

    // Straps caught after reset release, never loaded under reset
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_flex_reg <= `MODE_RST_DEDICATED;
            trst_rsv_reg  <= `TRST_RSV_RST;
        end else begin
            mode_flex_reg <= ~i_reserve_jtag;
            trst_rsv_reg  <= i_reserve_trst;
        end
    end

    // Edge of the sampled link clock; limitation: clock must be < sys/4
    assign tck_rise = tck_s & ~tck_last_reg;

    // Reserved test-reset pin clears the TAP without the clock
    // Hazard: a raw pad sits in this reset path, so a glitch on it resets the TAP
    assign tap_rst_n = i_rst_n & ~(trst_rsv_reg & ~i_trst_pin);

    tap_tracker u_tap (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (tap_rst_n),
        .i_tck_rise  (tck_rise),
        .i_tms       (tms_s),
        .o_state_reg (state)
    );

    assign in_reset = (state == `TAP_RESET);

    // Pin ownership and pad steering
    always @* begin
        // Dedicated: test always; flexible: test outside reset only
        o_test_owns_pins = ~mode_flex_reg | ~in_reset;
        o_tck_out        = 1'h0;
        o_tck_oe         = 1'h0;
        o_tdi_out        = 1'h0;
        o_tdi_oe         = 1'h0;
        o_tdo_out        = i_tdo_test;
        o_tdo_oe         = 1'h1;
        o_user_tck_in    = 1'h0;
        o_user_tdi_in    = 1'h0;
        o_user_tdo_in    = 1'h0;
        if (!o_test_owns_pins) begin
            o_tck_out     = i_user_tck_out;
            o_tck_oe      = i_user_tck_oe;
            o_tdi_out     = i_user_tdi_out;
            o_tdi_oe      = i_user_tdi_oe;
            o_tdo_out     = i_user_tdo_out;
            o_tdo_oe      = i_user_tdo_oe;
            o_user_tck_in = tck_s;
            o_user_tdi_in = tdi_s;
            o_user_tdo_in = 1'h0; // Output-only pad path toward user logic
        end
    end

    // Pull-ups only in dedicated mode; in flexible mode the board provides them
    always @* begin
        o_tms_pullup_en  = ~mode_flex_reg;
        o_tdi_pullup_en  = ~mode_flex_reg;
    end

    // Test-reset pin: reserved input with pull-up, or plain user I/O
    always @* begin
        o_trst_pullup_en = trst_rsv_reg;
        o_trst_out       = trst_rsv_reg ? 1'h0 : i_user_trst_out;
        o_trst_oe        = trst_rsv_reg ? 1'h0 : (i_trst_user_used & i_user_trst_oe);
        o_user_trst_in   = trst_rsv_reg ? 1'h0 : trst_s;
    end

    // Test-port view; mode-select never reaches user logic
    always @* begin
        o_tms_sync       = tms_s;
        o_tdi_sync       = o_test_owns_pins & tdi_s;
        o_tck_rise       = tck_rise;
        o_tap_reset      = in_reset;
        o_tap_state      = state;
    end

endmodule // jtag_pin_mode_control

// ==== jtag_tester.sv ====
// Purpose: Boundary-scan tester model driving the link clock and mode-select
// Assumes: Driven from the bench on falling system clock edges
// Notes:   Link clock idles low between frames, 900 ns per link clock
`timescale 1ns/1ps
module jtag_tester (
    input  wire i_sys_clk,
    output reg  o_tck,
    output reg  o_tms
);
    initial begin
        o_tck = 1'h0;
        o_tms = 1'h1;
    end
    // One link clock; select is set up four system clocks before the rise
    task step(input t);
        begin
            @(negedge i_sys_clk) o_tms = t;
            repeat (4) @(negedge i_sys_clk);
            o_tck = 1'h1;
            repeat (4) @(negedge i_sys_clk);
            o_tck = 1'h0;
        end
    endtask
    // Five clocks with select high always reach reset, whatever the state
    task to_reset;
        repeat (5) step(1'h1);
    endtask
endmodule // jtag_tester

// ==== jtag_pin_mode_asserts.sv ====
// Purpose: Concurrent checks on the scan-pin sharing block
// Assumes: Straps change rarely and hold for many clocks
// Notes:   Strap registers lag the straps one clock, hence the stable guards
`timescale 1ns/1ps
module jtag_pin_mode_asserts (
    input wire       i_sys_clk,
    input wire       i_rst_n,
    input wire       i_reserve_jtag,
    input wire       i_reserve_trst,
    input wire       i_trst_pin,
    input wire       o_tms_pullup_en,
    input wire       o_tdi_pullup_en,
    input wire       o_trst_pullup_en,
    input wire       o_test_owns_pins,
    input wire       o_tck_rise,
    input wire       o_tms_sync,
    input wire       o_tap_reset,
    input wire [3:0] o_tap_state
);
    reg [1:0] up_reg;
    // Straps load at the first edge after reset and are sampled a clock later, so wait two
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) up_reg <= 2'h0;
        else up_reg <= {up_reg[0], 1'h1};
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Rise with select low while in reset, test reset not pulling down
    sequence hand_seq;
        o_tck_rise && !o_tms_sync && o_tap_reset && (i_trst_pin || !i_reserve_trst);
    endsequence
    pullup_match_a: assert property (
        up_reg[1] && $stable(i_reserve_jtag) |->
        o_tms_pullup_en == i_reserve_jtag && o_tdi_pullup_en == i_reserve_jtag)
        else $error("Pull-ups disagree with mode strap");
    trst_pullup_a: assert property (up_reg[1] && $stable(i_reserve_trst) |->
        o_trst_pullup_en == i_reserve_trst) else $error("Test-reset pull-up wrong");
    ded_owns_a: assert property (up_reg[1] && $stable(i_reserve_jtag) &&
        i_reserve_jtag |-> o_test_owns_pins) else $error("Dedicated pins not held");
    flex_user_a: assert property (up_reg[1] && $stable(i_reserve_jtag) &&
        !i_reserve_jtag && o_tap_reset |-> !o_test_owns_pins) else $error("Pins not user");
    handover_a: assert property (hand_seq |=> !o_tap_reset && o_test_owns_pins)
        else $error("No handover after rise");
    state_hold_a: assert property (!o_tck_rise && i_trst_pin ##1 i_trst_pin |->
        $stable(o_tap_state)) else $error("State moved without link clock");
    trst_reset_a: assert property (up_reg[1] && $stable(i_reserve_trst) &&
        i_reserve_trst && !i_trst_pin |-> o_tap_reset) else $error("Test reset ignored");
    power_up_a: assert property ($rose(i_rst_n) |-> o_tap_reset)
        else $error("TAP not in reset after power-up");
    quiet_release_a: assert property ($rose(i_rst_n) |-> !o_tck_rise)
        else $error("Link clock edge seen at reset release");
endmodule // jtag_pin_mode_asserts
bind jtag_pin_mode_control jtag_pin_mode_asserts u_chk (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_reserve_jtag(i_reserve_jtag), .i_reserve_trst(i_reserve_trst),
    .i_trst_pin(i_trst_pin), .o_tms_pullup_en(o_tms_pullup_en),
    .o_tdi_pullup_en(o_tdi_pullup_en), .o_trst_pullup_en(o_trst_pullup_en),
    .o_test_owns_pins(o_test_owns_pins), .o_tck_rise(o_tck_rise),
    .o_tms_sync(o_tms_sync), .o_tap_reset(o_tap_reset), .o_tap_state(o_tap_state));

// ==== jtag_pin_mode_control_tb.sv ====
// Purpose: Directed bench for the scan-pin sharing block
// Assumes: Inputs change on falling system clock edges
// Notes:   User drive bits: tck out/oe, tdi out/oe, tdo out/oe, trst out/oe
`timescale 1ns/1ps
`include "jtag_pin_map.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("Error %0t: value mismatch", $time); end end
module jtag_pin_mode_control_tb;
    reg        clk, rst_n, rj, rt, tu, trst, tdi, tdo_t;
    wire       tdo_out, tdi_sync, utdi;
    reg  [7:0] u;
    wire       tck, tms, tck_oe, tdo_oe, trst_oe, pu_tms, pu_tdi, pu_trst, owns, tap_rst;
    wire [3:0] st;
    integer    failures = 0, checks = 0;
    jtag_tester P (.i_sys_clk(clk), .o_tck(tck), .o_tms(tms));
    jtag_pin_mode_control DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reserve_jtag(rj),
        .i_reserve_trst(rt), .i_trst_user_used(tu), .i_tms_pin(tms), .i_tck_pin(tck),
        .i_tdi_pin(tdi), .i_trst_pin(trst), .i_tdo_test(tdo_t), .i_user_tck_out(u[0]),
        .i_user_tck_oe(u[1]), .i_user_tdi_out(u[2]), .i_user_tdi_oe(u[3]),
        .i_user_tdo_out(u[4]), .i_user_tdo_oe(u[5]), .i_user_trst_out(u[6]),
        .i_user_trst_oe(u[7]), .o_tck_out(), .o_tck_oe(tck_oe), .o_tdi_out(),
        .o_tdi_oe(), .o_tdo_out(tdo_out), .o_tdo_oe(tdo_oe), .o_trst_out(), .o_trst_oe(trst_oe),
        .o_tms_pullup_en(pu_tms), .o_tdi_pullup_en(pu_tdi), .o_trst_pullup_en(pu_trst),
        .o_user_tck_in(), .o_user_tdi_in(utdi), .o_user_tdo_in(), .o_user_trst_in(),
        .o_test_owns_pins(owns), .o_tck_rise(), .o_tms_sync(), .o_tdi_sync(tdi_sync),
        .o_tap_reset(tap_rst), .o_tap_state(st));
    task wn(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task tally_and_finish;
        begin
            $display("checks=%0d failures=%0d", checks, failures);
            if (failures == 0 && checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // System clock, 100 ns period
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // Whole run is eight link clocks; this is far beyond it
    initial begin
        #100000 failures++;
        tally_and_finish;
    end
    // Flexible mode walk, test reset, then dedicated mode
    initial begin
        rst_n = 1'h0; rj = 1'h0; rt = 1'h0; tu = 1'h0; trst = 1'h1; u = 8'hAA;
        tdi = 1'h1; tdo_t = 1'h1;
        wn(5);
        rst_n = 1'h1;
        wn(3);
        `CHK(tap_rst, 1'h1)
        `CHK(owns, 1'h0)
        `CHK(tck_oe, u[1])
        `CHK({pu_tms, pu_tdi}, 2'h0)
        `CHK(trst_oe, 1'h0)
        `CHK({tdo_out, utdi, tdi_sync}, 3'h2)
        P.step(1'h0); wn(1);
        `CHK(owns, 1'h1)
        `CHK({tck_oe, tdo_oe}, 2'h1)
        `CHK({tdo_out, utdi, tdi_sync}, 3'h5)
        P.to_reset; wn(1);
        `CHK(owns, 1'h0)
        rt = 1'h1; tu = 1'h1; P.step(1'h0); wn(1);
        `CHK(pu_trst, 1'h1)
        `CHK(trst_oe, 1'h0)
        `CHK(owns, 1'h1)
        trst = 1'h0; wn(1);
        `CHK({tap_rst, owns}, 2'h2)
        rj = 1'h1; trst = 1'h1; wn(2);
        `CHK({owns, pu_tms, pu_tdi}, 3'h7)
        `CHK(tck_oe, 1'h0)
        P.step(1'h0); wn(1);
        `CHK(st, `TAP_IDLE)
        rst_n = 1'h0; wn(2);
        rst_n = 1'h1; wn(3);
        `CHK({tap_rst, owns}, 2'h3)
        tally_and_finish;
    end
endmodule // jtag_pin_mode_control_tb
